// ===== include/scc_pkg.sv
// Constants and types for the sampler cycle controller.
// Assumes a 20 MHz system clock; all times derive from CLK_HZ.
package scc_pkg;
  // ==========================================
  // Clock and timing
  localparam int CLK_HZ     = 20_000_000;
  localparam int DEB_US     = 100;
  // Least time, so round up to whole cycles
  localparam int DEB_CYC    = (DEB_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int DEB_W      = 12;
  localparam int STALL_MS   = 2000;
  localparam int STALL_DEF  = STALL_MS * (CLK_HZ / 1000);
  localparam int STALL_W    = 26;
  // ==========================================
  // Input vector positions
  localparam int N_IN       = 5;
  localparam int IX_TRIG    = 0;
  localparam int IX_FLUID   = 1;
  localparam int IX_FULL    = 2;
  localparam int IX_LID     = 3;
  localparam int IX_ROT     = 4;
  // ==========================================
  // Pump, spout and counter sizes
  localparam int PULSES_REV = 16;
  localparam int SUB_W      = 4;
  localparam int REV_W      = 24;
  localparam int CNT_W      = 16;
  localparam int RINSE_W    = 4;
  localparam int BOTTLES    = 24;
  localparam int STEP_DEG   = 15;
  localparam int BOT_W      = 5;
  localparam logic [BOT_W-1:0] LAST_BOT = BOT_W'(BOTTLES - 1);
  localparam logic AUTO_RESTART_ON = 1'b1;
  // ==========================================
  // Cycle sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_PURGE, ST_RDRAW, ST_RPURGE, ST_DRAW,
    ST_RETRY, ST_FILL, ST_POST, ST_STEP
  } scc_state_t;
endpackage

// ===== include/scc_if.sv
// Carrier between sequencer, input conditioner and pump monitor.
// All signals live in the i_clk_sys domain.
`timescale 1ns/100ps
interface scc_if import scc_pkg::*; ();
  logic             trig;
  logic             fluid;
  logic             full;
  logic             lid_open;
  logic             rot_pulse;
  logic             motor_on;
  logic             rot_fault;
  logic             wear_warn;
  logic [REV_W-1:0] rev_total;
  modport deb (output trig, fluid, full, lid_open, rot_pulse);
  modport rot (input rot_pulse, motor_on,
               output rot_fault, wear_warn, rev_total);
  modport ctl (input trig, fluid, full, lid_open, rot_pulse,
               rot_fault, wear_warn, rev_total, output motor_on);
endinterface

// ===== rtl/scc_debounce.sv
// Synchroniser and debouncer for the switch and sensor inputs.
// Raw inputs are active high; a level must hold DEB_CYC cycles.
`timescale 1ns/100ps
module scc_debounce import scc_pkg::*; (
  // Clock and reset
  input  wire logic            i_clk_sys,
  input  wire logic            i_rst,
  // Raw inputs
  input  wire logic [N_IN-1:0] i_raw,
  // Clean levels out
  scc_if.deb                   sens
);
  logic [N_IN-1:0] s1_reg;
  logic [N_IN-1:0] s2_reg;
  logic [N_IN-1:0] clean_reg;
  logic            rot_d_reg;
  logic            rot_pulse_reg;

  // ==========================================
  // Two-stage synchroniser
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= i_raw;
      s2_reg <= s1_reg;
    end
  end

  // ==========================================
  // Per-input stability counter
  genvar g;
  generate
    for (g = 0; g < N_IN; g++) begin : g_deb
      logic [DEB_W-1:0] cnt_reg;
      always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          cnt_reg      <= '0;
          clean_reg[g] <= 1'b0;
        end else if (s2_reg[g] == clean_reg[g]) begin
          cnt_reg <= '0;
        end else if (cnt_reg == DEB_W'(DEB_CYC - 1)) begin
          cnt_reg      <= '0;
          clean_reg[g] <= s2_reg[g];
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  endgenerate

  // ==========================================
  // One-cycle event per rotation slot
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rot_d_reg     <= 1'b0;
      rot_pulse_reg <= 1'b0;
    end else begin
      rot_d_reg     <= clean_reg[IX_ROT];
      rot_pulse_reg <= clean_reg[IX_ROT] & ~rot_d_reg;
    end
  end

  assign sens.trig      = clean_reg[IX_TRIG];
  assign sens.fluid     = clean_reg[IX_FLUID];
  assign sens.full      = clean_reg[IX_FULL];
  assign sens.lid_open  = clean_reg[IX_LID];
  assign sens.rot_pulse = rot_pulse_reg;
endmodule // scc_debounce

// ===== rtl/scc_rot_mon.sv
// Pump rotation monitor: stall watchdog and revolution tally.
// Expects one rot_pulse per slot of the shaft disk.
`timescale 1ns/100ps
module scc_rot_mon import scc_pkg::*; #(
  parameter int STALL_CYC = STALL_DEF
) (
  // Clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  // Control
  input  wire logic             i_fault_clr,
  input  wire logic [REV_W-1:0] i_wear_limit,
  // Pump side
  scc_if.rot                    pm
);
  logic [STALL_W-1:0] stall_reg;
  logic [SUB_W-1:0]   sub_reg;
  logic [REV_W-1:0]   rev_reg;
  logic               fault_reg;
  logic               wear_reg;
  logic               stall_hit;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  assign stall_hit = (stall_reg == STALL_W'(STALL_CYC));

  // ==========================================
  // Stall watchdog, runs only while driven
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      stall_reg <= '0;
    end else if (!pm.motor_on || pm.rot_pulse) begin
      stall_reg <= '0;
    end else if (!stall_hit) begin
      stall_reg <= stall_reg + 1'b1;
    end
  end

  // Set wins over clear
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      fault_reg <= 1'b0;
    end else if (stall_hit) begin
      fault_reg <= 1'b1;
    end else if (i_fault_clr) begin
      fault_reg <= 1'b0;
    end
  end

  // ==========================================
  // Revolution tally for tubing wear
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sub_reg <= '0;
      rev_reg <= '0;
    end else if (pm.rot_pulse) begin
      sub_reg <= sub_reg + 1'b1;
      if (sub_reg == SUB_W'(PULSES_REV - 1)) begin
        rev_reg <= rev_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wear_reg <= 1'b0;
    end else begin
      wear_reg <= (rev_reg >= i_wear_limit);
    end
  end

  assign pm.rot_fault = fault_reg;
  assign pm.wear_warn = wear_reg;
  assign pm.rev_total = rev_reg;

  chk_stall_fault : assert property (
    stall_hit |=> fault_reg)
    else $error("stall did not raise the rotation fault");
  chk_rev_count : assert property (
    pm.rot_pulse && sub_reg == 4'hF |=> rev_reg == $past(rev_reg) + 1)
    else $error("sixteen pulses did not add one revolution");
endmodule // scc_rot_mon

// ===== rtl/scc_cycle_ctl.sv
// Sample cycle sequencer for a peristaltic liquid sampler.
// Field inputs are raw switch levels, active high (i_lid_closed_sw high reads as lid open), synchronised to i_clk_sys inside.
// Function
// - see: cycle relay closed during each cycle
// - see: two draw attempts before missed sample
// - see: missed relay at end, cleared next cycle
// - see: full/end relay on single-bottle full or last bottle
// - see: auto restart setting resumes after outage
// - see: purge counter-clockwise, draw clockwise
// - see: rotation pulse equals sixteenth revolution
// - see: volume measured by rotation pulse count
// - see: running revolution total warns tubing wear
// - see: no pulses while driven stops motor, faults
// - see: lid absent blocks pump, raises fault
// - see: single bottle full stops new draws
// - see: spout steps clockwise one bottle, 15 deg
// - see: every cycle begins with intake purge
// - see: each rinse draws to fluid, then purges
// - see: draw uses fluid sensor plus pulse count
`timescale 1ns/100ps
module scc_cycle_ctl import scc_pkg::*; #(
  parameter int STALL_CYC = STALL_DEF
) (
  // Clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  // Field inputs
  input  wire logic             i_trig,
  input  wire logic             i_fluid,
  input  wire logic             i_full,
  input  wire logic             i_lid_closed_sw,
  input  wire logic             i_rot,
  // Configuration
  input  wire logic             i_multi,
  input  wire logic [RINSE_W-1:0] i_rinses,
  input  wire logic [CNT_W-1:0] i_purge_pulses,
  input  wire logic [CNT_W-1:0] i_draw_max,
  input  wire logic [CNT_W-1:0] i_vol_pulses,
  input  wire logic [REV_W-1:0] i_wear_limit,
  input  wire logic             i_auto_restart,
  // Operator controls
  input  wire logic             i_run,
  input  wire logic             i_halt,
  input  wire logic             i_seq_reset,
  input  wire logic             i_fault_clr,
  input  wire logic             i_msg_clr,
  // Pump and spout drive
  output logic                  o_motor_on,
  output logic                  o_motor_cw,
  output logic                  o_step,
  output logic                  o_step_cw,
  output logic [BOT_W-1:0]      o_bottle,
  // Relays
  output logic                  o_relay_cycle,
  output logic                  o_relay_missed,
  output logic                  o_relay_full,
  // Status
  output logic                  o_running,
  output logic                  o_lid_fault,
  output logic                  o_rotation_feedback_fault_msg,
  output logic                  o_supply_dropout_msg,
  output logic                  o_wear_warn,
  output logic [REV_W-1:0]      o_rev_total
);
  scc_if sif ();

  scc_state_t       state_reg, state_next;
  logic [CNT_W-1:0] seg_reg;
  logic [RINSE_W-1:0] rinse_reg, rinse_next;
  logic             att_reg, att_next;
  logic             miss_reg, miss_next;
  logic             end_evt, step_evt, last_evt;
  logic             trig_d_reg, boot_reg, run_reg, msg_reg;
  logic             motor_reg, cw_reg, step_reg, lid_reg;
  logic             rcyc_reg, rmiss_reg, rfull_reg;
  logic [BOT_W-1:0] bot_reg;
  logic             start_go, can_start, active, purge_done;
  logic             draw_lim, vol_done;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // ==========================================
  // Input conditioning and pump monitor
  scc_debounce u_deb (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_raw     ({i_rot, i_lid_closed_sw, i_full, i_fluid, i_trig}),
    .sens      (sif.deb)
  );

  scc_rot_mon #(.STALL_CYC(STALL_CYC)) u_rot (
    .i_clk_sys    (i_clk_sys),
    .i_rst        (i_rst),
    .i_fault_clr  (i_fault_clr),
    .i_wear_limit (i_wear_limit),
    .pm           (sif.rot)
  );

  // ==========================================
  // Power-up: resume only when configured to
  // Strap is caught after release, not under reset
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      boot_reg <= 1'b1;
      run_reg  <= 1'b0;
      msg_reg  <= 1'b0;
    end else if (boot_reg) begin
      boot_reg <= 1'b0;
      run_reg  <= (i_auto_restart == AUTO_RESTART_ON);
      msg_reg  <= 1'b1;
    end else begin
      if (i_halt) begin
        run_reg <= 1'b0;
      end else if (i_run) begin
        run_reg <= 1'b1;
      end
      if (i_msg_clr) begin
        msg_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // Start qualification
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      trig_d_reg <= 1'b0;
    end else begin
      trig_d_reg <= sif.trig;
    end
  end

  assign can_start = run_reg && !rfull_reg && !sif.rot_fault &&
                     !(!i_multi && sif.full);
  assign start_go  = (state_reg == ST_IDLE) && sif.trig &&
                     !trig_d_reg && can_start;
  assign purge_done = (seg_reg >= i_purge_pulses);
  assign draw_lim   = (seg_reg >= i_draw_max);
  assign vol_done   = (seg_reg >= i_vol_pulses);

  // ==========================================
  // Cycle sequencer
  always_comb begin
    state_next = state_reg;
    rinse_next = rinse_reg;
    att_next   = att_reg;
    miss_next  = miss_reg;
    end_evt    = 1'b0;
    step_evt   = 1'b0;
    last_evt   = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (start_go) begin
          state_next = ST_PURGE;
          rinse_next = i_rinses;
          att_next   = 1'b0;
          miss_next  = 1'b0;
        end
      end
      ST_PURGE: begin
        if (purge_done) begin
          state_next = (rinse_reg != '0) ? ST_RDRAW : ST_DRAW;
        end
      end
      ST_RDRAW: begin
        // Dry rinse gives up at the draw limit
        if (sif.fluid || draw_lim) begin
          state_next = ST_RPURGE;
        end
      end
      ST_RPURGE: begin
        if (purge_done) begin
          rinse_next = rinse_reg - 1'b1;
          state_next = (rinse_reg == 4'h1) ? ST_DRAW : ST_RDRAW;
        end
      end
      ST_DRAW: begin
        if (sif.fluid) begin
          state_next = ST_FILL;
        end else if (draw_lim && !att_reg) begin
          att_next   = 1'b1;
          state_next = ST_RETRY;
        end else if (draw_lim) begin
          miss_next  = 1'b1;
          state_next = ST_POST;
        end
      end
      ST_RETRY: begin
        if (purge_done) begin
          state_next = ST_DRAW;
        end
      end
      ST_FILL: begin
        // Count runs from the moment fluid reached the sensor
        if (vol_done) begin
          state_next = ST_POST;
        end
      end
      ST_POST: begin
        if (purge_done && i_multi && bot_reg == LAST_BOT) begin
          last_evt   = 1'b1;
          end_evt    = 1'b1;
          state_next = ST_IDLE;
        end else if (purge_done && i_multi) begin
          state_next = ST_STEP;
        end else if (purge_done) begin
          end_evt    = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_STEP: begin
        step_evt   = 1'b1;
        end_evt    = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Rotation fault abandons the cycle as missed
    if (state_reg != ST_IDLE && sif.rot_fault) begin
      state_next = ST_IDLE;
      miss_next  = 1'b1;
      end_evt    = 1'b1;
      step_evt   = 1'b0;
      last_evt   = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      rinse_reg <= '0;
      att_reg   <= 1'b0;
      miss_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      rinse_reg <= rinse_next;
      att_reg   <= att_next;
      miss_reg  <= miss_next;
    end
  end

  // Pulses per segment; saturates rather than wraps
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      seg_reg <= '0;
    end else if (state_next != state_reg) begin
      seg_reg <= '0;
    end else if (sif.rot_pulse && seg_reg != '1) begin
      seg_reg <= seg_reg + 1'b1;
    end
  end

  chk_start_purge : assert property (
    start_go |=> state_reg == ST_PURGE)
    else $error("cycle did not open with a purge");
  chk_retry_draw : assert property (
    state_reg == ST_DRAW && !sif.fluid && draw_lim && !att_reg
      && !sif.rot_fault |=> state_reg == ST_RETRY ##0 att_reg)
    else $error("first failed draw did not retry");
  chk_full_block : assert property (
    !i_multi && sif.full |-> !start_go)
    else $error("draw started on a full single bottle");

  // ==========================================
  // Pump motor drive, gated by lid and fault
  assign active = (state_reg != ST_IDLE) && (state_reg != ST_STEP);
  assign sif.motor_on = motor_reg;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      motor_reg <= 1'b0;
      cw_reg    <= 1'b0;
      lid_reg   <= 1'b0;
    end else begin
      motor_reg <= active && !sif.lid_open
                   && !sif.rot_fault;
      cw_reg    <= (state_reg == ST_RDRAW) || (state_reg == ST_DRAW)
                   || (state_reg == ST_FILL);
      lid_reg   <= sif.lid_open;
    end
  end

  chk_lid_stop : assert property (
    sif.lid_open |=> !motor_reg && lid_reg)
    else $error("pump ran with the lid absent");
  chk_purge_ccw : assert property (
    state_reg == ST_PURGE |=> !cw_reg)
    else $error("purge did not turn counter-clockwise");
  chk_fault_stop : assert property (
    sif.rot_fault |=> !motor_reg)
    else $error("motor powered after rotation fault");

  // ==========================================
  // Alarm relays and spout
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rcyc_reg  <= 1'b0;
      rmiss_reg <= 1'b0;
      rfull_reg <= 1'b0;
    end else begin
      rcyc_reg <= (state_next != ST_IDLE);
      if (end_evt && miss_next) begin
        rmiss_reg <= 1'b1;
      end else if (start_go) begin
        rmiss_reg <= 1'b0;
      end
      // Set wins over the sequence reset
      if (last_evt || (!i_multi && sif.full)) begin
        rfull_reg <= 1'b1;
      end else if (i_seq_reset) begin
        rfull_reg <= 1'b0;
      end
    end
  end

  // Spout only turns one way; no homing logic here
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      bot_reg  <= '0;
      step_reg <= 1'b0;
    end else begin
      step_reg <= step_evt;
      if (step_evt) begin
        bot_reg <= bot_reg + 1'b1;
      end else if (i_seq_reset && state_reg == ST_IDLE) begin
        bot_reg <= '0;
      end
    end
  end

  chk_cycle_relay : assert property (
    start_go |=> rcyc_reg ##0 (rcyc_reg throughout
      (state_reg != ST_IDLE)[*2]))
    else $error("cycle relay open during a cycle");
  chk_missed_set : assert property (
    end_evt && miss_next |=> rmiss_reg && !rcyc_reg)
    else $error("missed relay not closed at cycle end");
  chk_missed_clr : assert property (
    start_go |=> !rmiss_reg)
    else $error("missed relay not cleared by new cycle");
  chk_last_full : assert property (
    last_evt |=> rfull_reg && bot_reg == LAST_BOT)
    else $error("end relay not closed after last bottle");
  chk_step_one : assert property (
    step_evt |=> step_reg && bot_reg == $past(bot_reg) + 1)
    else $error("spout did not advance one position");

  cov_retry : cover property (state_reg == ST_RETRY);
  cov_missed : cover property (end_evt && miss_next);
  cov_step : cover property (step_evt);
  cov_rinse : cover property (state_reg == ST_RPURGE);

  // ==========================================
  // Outputs
  assign o_motor_on     = motor_reg;
  assign o_motor_cw     = cw_reg;
  assign o_step         = step_reg;
  assign o_step_cw      = run_reg | ~run_reg;
  assign o_bottle       = bot_reg;
  assign o_relay_cycle  = rcyc_reg;
  assign o_relay_missed = rmiss_reg;
  assign o_relay_full   = rfull_reg;
  assign o_running      = run_reg;
  assign o_lid_fault    = lid_reg;
  assign o_rotation_feedback_fault_msg = sif.rot_fault;
  assign o_supply_dropout_msg = msg_reg;
  assign o_wear_warn    = sif.wear_warn;
  assign o_rev_total    = sif.rev_total;
endmodule // scc_cycle_ctl

// ===== verification/scc_pump_model.sv
// Behavioural pump with rotation sensor and intake fluid sensor.
// Assumes the controller clock; pulse half width comes from the bench.
`timescale 1ns/100ps
module scc_pump_model (
  // Clock
  input  wire logic        i_clk_sys,
  // Drive from the controller
  input  wire logic        i_motor_on,
  input  wire logic        i_motor_cw,
  // Bench commands
  input  wire logic        i_stall,
  input  wire logic        i_wet,
  input  wire logic [15:0] i_half_cyc,
  // Sensor outputs
  output logic             o_rot,
  output logic             o_fluid,
  output logic [31:0]      o_pulses
);
  logic [15:0] ph_reg;
  logic        cw_reg;

  initial begin
    ph_reg   = 16'h0000;
    cw_reg   = 1'b0;
    o_rot    = 1'b0;
    o_pulses = 32'h0;
  end

  // ==========================================
  // Shaft: one slot per sixteenth turn; a stopped shaft keeps its level
  always @(posedge i_clk_sys) begin
    if (i_motor_on && !i_stall) begin
      ph_reg <= (ph_reg >= 2 * i_half_cyc - 16'h0001) ? 16'h0000
                                                      : ph_reg + 16'h0001;
      o_rot  <= (ph_reg < i_half_cyc);
      if (ph_reg == 16'h0000) begin
        o_pulses <= o_pulses + 32'h1;
      end
    end
  end

  // ==========================================
  // Fluid reaches the sensor only after drawing, leaves on purge
  always @(posedge i_clk_sys) begin
    if (i_motor_on) begin
      cw_reg <= i_motor_cw;
    end
  end
  assign o_fluid = i_wet && cw_reg;
endmodule // scc_pump_model

// ===== verification/scc_cycle_ctl_tb_top.sv
// Self-checking bench for the sample cycle sequencer.
// Assumes the pump model; every input change waits out the debouncer.
`timescale 1ns/100ps
module scc_cycle_ctl_tb_top import scc_pkg::*; ;
  localparam int STALL = 8000;
  localparam int LIMIT = 105000;
  logic clk, rst, trig, full, lid, multi, seq_rst, f_clr, m_clr;
  logic stall, wet, run, halt, auto_rs, rot, fluid;
  logic [RINSE_W-1:0] rinses;
  logic [CNT_W-1:0]   purge_p, draw_max, vol_p;
  logic [REV_W-1:0]   wear_lim, rev_total;
  logic [15:0]        half;
  logic [BOT_W-1:0]   bottle;
  logic [31:0]        pulses, seed;
  logic motor_on, motor_cw, step, step_cw, rel_cyc, rel_miss, rel_full;
  logic running, lid_fault, rot_fault, dropout, wear_warn, dr_q;
  int   error_cnt, cmp_count, draws, steps, cyc;
  wire  [4:0] mon = {rot_fault, motor_on, rel_full, rel_miss, rel_cyc};

  scc_cycle_ctl #(.STALL_CYC(STALL)) scc_cycle_ctl_inst (
    .i_clk_sys(clk), .i_rst(rst), .i_trig(trig), .i_fluid(fluid),
    .i_full(full), .i_lid_closed_sw(lid), .i_rot(rot), .i_multi(multi),
    .i_rinses(rinses), .i_purge_pulses(purge_p), .i_draw_max(draw_max),
    .i_vol_pulses(vol_p), .i_wear_limit(wear_lim),
    .i_auto_restart(auto_rs), .i_run(run), .i_halt(halt),
    .i_seq_reset(seq_rst), .i_fault_clr(f_clr), .i_msg_clr(m_clr),
    .o_motor_on(motor_on), .o_motor_cw(motor_cw), .o_step(step),
    .o_step_cw(step_cw), .o_bottle(bottle), .o_relay_cycle(rel_cyc),
    .o_relay_missed(rel_miss), .o_relay_full(rel_full),
    .o_running(running), .o_lid_fault(lid_fault),
    .o_rotation_feedback_fault_msg(rot_fault),
    .o_supply_dropout_msg(dropout), .o_wear_warn(wear_warn),
    .o_rev_total(rev_total));

  scc_pump_model scc_pump_model_inst (
    .i_clk_sys(clk), .i_motor_on(motor_on), .i_motor_cw(motor_cw),
    .i_stall(stall), .i_wet(wet), .i_half_cyc(half), .o_rot(rot),
    .o_fluid(fluid), .o_pulses(pulses));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================
  // Monitors: draw segments, spout steps, hang limit
  always @(posedge clk) begin
    dr_q <= motor_on & motor_cw;
    if (motor_on & motor_cw & !dr_q) draws++;
    if (step === 1'b1) steps++;
    cyc++;
    if (cyc == LIMIT) begin
      error_cnt++;
      final_report();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [31:0] exp_draws(input logic [3:0] r,
                                            input logic dry);
    return dry ? 32'h2 : 32'(r) + 32'h1;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wait_bit(input int ix, input logic v, input int max);
    int n;
    n = 0;
    while (mon[ix] !== v && n < max) begin
      @(negedge clk);
      n++;
    end
    if (mon[ix] !== v) begin
      error_cnt++;
      $display("[ERR] %0t wait on monitor %0d ran out", $time, ix);
    end
  endtask

  // Raises the trigger, optionally holds the lid off, waits for the end
  task automatic run_cycle(input logic hold, input int max);
    draws = 0;
    steps = 0;
    // Held only past the debounce time to keep runs short
    trig  = 1'b1;
    wait_bit(0, 1'b1, 2300);
    chk(32'(rel_cyc), 32'h1);
    trig = 1'b0;
    repeat (3) @(negedge clk);
    chk(32'(rel_miss), 32'h0);
    if (hold) begin
      repeat (3000) @(negedge clk);
      chk(32'(motor_on), 32'h0);
      lid = 1'b0;
    end
    wait_bit(3, 1'b1, 2300);
    chk(32'(motor_cw), 32'h0);
    wait_bit(0, 1'b0, max);
    repeat (2) @(negedge clk);
  endtask

  task automatic final_report();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    {trig, full, lid, multi, seq_rst, f_clr, m_clr, stall} = 8'h00;
    {run, halt, wet} = 3'h0;
    auto_rs  = 1'b1;
    rinses   = 4'h0;
    purge_p  = 16'h0001;
    // Two pulses outlast the fluid debounce, so a wet draw never retries
    draw_max = 16'h0002;
    vol_p    = 16'h0001;
    seed     = xs(32'hD504);
    half     = 16'h0820 + 16'(seed[5:0]);
    seed     = xs(seed);
    wear_lim = 24'h000100 + 24'(seed[7:0]);
    rst      = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk(32'(dropout), 32'h1);
    chk(32'(running), 32'h1);
    m_clr = 1'b1;
    @(negedge clk);
    m_clr = 1'b0;
    @(negedge clk);
    chk(32'(dropout), 32'h0);
    wet = 1'b1;
    run_cycle(1'b0, 40000);
    chk(32'(draws), exp_draws(rinses, 1'b0));
    chk(32'(rel_miss), 32'h0);
    chk(32'(bottle), 32'h0);
    wet = 1'b0;
    run_cycle(1'b0, 50000);
    chk(32'(draws), exp_draws(rinses, 1'b1));
    chk(32'(rel_miss), 32'h1);
    // Lid off before the trigger; multi-bottle with one rinse
    {wet, multi, lid} = 3'b111;
    rinses = 4'h1;
    // Two-pulse purge lets the rinse fluid clear the sensor
    purge_p = 16'h0002;
    repeat (2100) @(negedge clk);
    chk(32'(lid_fault), 32'h1);
    run_cycle(1'b1, 60000);
    chk(32'(draws), exp_draws(rinses, 1'b0));
    chk(32'(steps), 32'h1);
    chk(32'(bottle), 32'h1);
    chk(32'(step_cw), 32'h1);
    {multi, stall} = 2'b01;
    rinses = 4'h0;
    run_cycle(1'b0, STALL + 3000);
    chk(32'(rot_fault), 32'h1);
    chk(32'(motor_on), 32'h0);
    chk(32'(rel_miss), 32'h1);
    {stall, f_clr} = 2'b01;
    @(negedge clk);
    f_clr = 1'b0;
    @(negedge clk);
    chk(32'(rot_fault), 32'h0);
    chk(32'(rev_total), pulses >> 4);
    chk(32'(wear_warn), 32'h0);
    full = 1'b1;
    repeat (2100) @(negedge clk);
    chk(32'(rel_full), 32'h1);
    trig = 1'b1;
    repeat (2300) @(negedge clk);
    chk(32'(rel_cyc), 32'h0);
    // Mid-run outage with auto restart off
    auto_rs = 1'b0;
    rst     = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk(32'(running), 32'h0);
    chk(32'(dropout), 32'h1);
    chk(32'(rel_full), 32'h0);
    final_report();
  end
endmodule // scc_cycle_ctl_tb_top
